// ===== common/ces_defines.svh
// Register indices, field positions, reset values and limits for the CAN error/status block
`ifndef CES_DEFINES_SVH
`define CES_DEFINES_SVH

// Register indices; byte address is four times the index
`define CES_IDX_GSR_LOW 12'h031A
`define CES_IDX_GSR_HIGH 12'h031B
`define CES_IDX_GIF 12'h0320
`define CES_IDX_REC 12'h032E
`define CES_IDX_TEC 12'h032F
`define CES_ADDR_W 12

// Global state low fields
`define CES_GLOBAL_STATE_LOW_CCE_BIT 7
`define CES_GLOBAL_STATE_LOW_SMA_BIT 6
`define CES_GLOBAL_STATE_LOW_HMA_BIT 5
`define CES_GLOBAL_STATE_LOW_TSO_BIT 3
`define CES_GLOBAL_STATE_LOW_BO_BIT 2
`define CES_GLOBAL_STATE_LOW_EP_BIT 1
`define CES_GLOBAL_STATE_LOW_EW_BIT 0

// Global state high fields
`define CES_GLOBAL_STATE_HIGH_SLOT_LSB 4
`define CES_GLOBAL_STATE_HIGH_RX_BIT 3
`define CES_GLOBAL_STATE_HIGH_TX_BIT 2

// Flag register bit that clears the wrap flag
`define CES_GIF_TSWRAP_BIT 3

// Reset values
`define CES_SLOT_NONE 4'hF
`define CES_CNT_RST 9'h000

// Error confinement limits
`define CES_WARN_LIMIT 9'd96
`define CES_PASSIVE_LIMIT 9'd128
`define CES_BUSOFF_LIMIT 9'd256
`define CES_REC_RELOAD 9'd119
`define CES_ERR_STEP_BIG 9'd8
`define CES_RECOVERY_COUNT 8'd128

// Bus answers
`define CES_RESP_OKAY 2'b00
`define CES_RESP_SLVERR 2'b10

`endif

// ===== common/ces_pkg.sv
// Types for the CAN error/status block
package ces_pkg;

  typedef enum logic [2:0] {
    CES_ERR_ACTIVE = 3'b001,
    CES_ERR_PASSIVE = 3'b010,
    CES_BUS_OFF = 3'b100
  } ces_err_state_t;

endpackage

// ===== rtl/ces_error_status.sv
// CAN global status, error counters and error confinement with an AXI4-Lite slave
`timescale 1ns/1ps
`include "ces_defines.svh"

// Summary of operation
// - Slot field shows mailbox 0 to 14 in transmit slot, all ones when none.
// - Receive-active bit set while bus busy, this node is not transmitting and not bus off.
// - Transmit-active bit set from transmit start outside bus off until bus idle or arbitration lost.
// - Configuration acknowledge bit follows configuration mode and reads one after reset.
// - Sleep acknowledge bit reads one only once sleep mode is entered.
// - Halt acknowledge bit reads one only once halt mode is entered.
// - Sticky wrap status set on counter overflow, cleared only with the flag.
// - Transmit error count reaching 256 enters bus off and sets its bit.
// - During bus off the node neither transmits nor accepts messages.
// - Bus off ends on its own after the recovery sequence.
// - Error counter contents are undefined during bus off.
// - Passive bit set when either count is at least 128 outside bus off, else cleared.
// - Warning bit set when either count exceeds 96 outside bus off, else cleared.
// - Counters always readable; writes load both from low byte only in test mode.
// - Counters rise and fall by the standard error confinement rules.
// - Errors while both counts below 128 send an active error flag.
// - Errors while either count at least 128 send a passive error flag.
// - Receive count stops rising at the passive limit of 128.
// - Good reception at receive count 128 reloads it within 119 to 127.
// - After reset release the node is error active.
// - 128 sightings of 11 recessive bits end bus off and clear counters.
// - Entering configuration mode clears both counters.
// - Writing one to the flag bit clears flag and wrap status together.
module ces_error_status
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`CES_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`CES_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic config_mode_in,
  input wire logic sleep_mode_in,
  input wire logic halt_mode_in,
  input wire logic error_test_mode_bit,
  input wire logic tx_slot_valid,
  input wire logic [3:0] tx_slot_mailbox,
  input wire logic bus_idle,
  input wire logic tx_start,
  input wire logic arb_lost,
  input wire logic ts_overflow,
  input wire logic rx_error,
  input wire logic rx_error_severe,
  input wire logic tx_error,
  input wire logic tx_success,
  input wire logic rx_success,
  input wire logic recessive11_seen,
  output logic bus_participate_en,
  output logic active_error_flag_sel,
  output logic passive_error_flag_sel,
  output logic bus_off_status,
  output logic error_passive_status,
  output logic warning_level_status,
  output logic timestamp_wrap_irq_flag_clear
);

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [`CES_ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic bvalid;
  logic [1:0] bresp;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic next_aw_held;
  logic next_w_held;
  logic [`CES_ADDR_W-1:0] next_aw_addr;
  logic [7:0] next_w_byte;
  logic next_w_lane0;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic wr_fire;
  logic [`CES_ADDR_W-3:0] wr_idx;
  logic [`CES_ADDR_W-3:0] rd_idx;
  logic wr_counters;
  logic wr_flag_clear;

  logic [7:0] gsr_low;
  logic [7:0] gsr_high;
  logic [8:0] rx_error_count;
  logic [8:0] tx_error_count;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // Write happens once address and data are both in, in either order
  assign wr_fire = aw_held && w_held && !bvalid;
  assign wr_idx = aw_addr[`CES_ADDR_W-1:2];
  assign rd_idx = s_axi_araddr[`CES_ADDR_W-1:2];
  assign wr_counters = wr_fire && w_lane0 && error_test_mode_bit
    && (wr_idx == `CES_IDX_REC || wr_idx == `CES_IDX_TEC);
  assign wr_flag_clear = wr_fire && w_lane0 && (wr_idx == `CES_IDX_GIF)
    && w_byte[`CES_GIF_TSWRAP_BIT];

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_byte = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_awvalid && !aw_held)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held)
    begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      // Status halves accept the write but keep hardware values
      unique case (wr_idx)
        `CES_IDX_GSR_LOW, `CES_IDX_GSR_HIGH, `CES_IDX_GIF,
        `CES_IDX_REC, `CES_IDX_TEC:
          next_bresp = `CES_RESP_OKAY;
        default:
          next_bresp = `CES_RESP_SLVERR;
      endcase
    end
    else if (bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid)
    begin
      next_rvalid = 1'b1;
      next_rdata = 32'h0000_0000;
      next_rresp = `CES_RESP_OKAY;
      unique case (rd_idx)
        `CES_IDX_GSR_LOW:
          next_rdata[7:0] = gsr_low;
        `CES_IDX_GSR_HIGH:
          next_rdata[7:0] = gsr_high;
        `CES_IDX_GIF:
          next_rdata[7:0] = 8'h00;
        `CES_IDX_REC:
          next_rdata[7:0] = rx_error_count[7:0];
        `CES_IDX_TEC:
          next_rdata[7:0] = tx_error_count[7:0];
        default:
          next_rresp = `CES_RESP_SLVERR;
      endcase
    end
    else if (rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `CES_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `CES_RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_byte <= next_w_byte;
      w_lane0 <= next_w_lane0;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ----------------------------------------------------------------
  // Mode acknowledges, activity and slot
  // ----------------------------------------------------------------
  logic config_entered_ack;
  logic sleep_entered_ack;
  logic halt_entered_ack;
  logic receive_active;
  logic transmit_active;
  logic timestamp_overflow_status;
  logic [3:0] pending_tx_mailbox;
  logic flag_clear_q;
  logic next_config_entered_ack;
  logic next_sleep_entered_ack;
  logic next_halt_entered_ack;
  logic next_receive_active;
  logic next_transmit_active;
  logic next_timestamp_overflow_status;
  logic [3:0] next_pending_tx_mailbox;
  logic config_entry;
  ces_pkg::ces_err_state_t err_state;

  assign config_entry = config_mode_in && !config_entered_ack;

  always_comb
  begin
    next_config_entered_ack = config_mode_in;
    next_sleep_entered_ack = sleep_mode_in;
    next_halt_entered_ack = halt_mode_in;
    next_pending_tx_mailbox = tx_slot_valid ? tx_slot_mailbox : `CES_SLOT_NONE;
    next_transmit_active = transmit_active;
    if (bus_idle || arb_lost)
    begin
      next_transmit_active = 1'b0;
    end
    else if (tx_start && err_state != ces_pkg::CES_BUS_OFF)
    begin
      next_transmit_active = 1'b1;
    end
    // Bus off keeps the node deaf as well as mute
    next_receive_active = !bus_idle && !next_transmit_active
      && err_state != ces_pkg::CES_BUS_OFF;
    // Overflow in the clearing cycle wins, so no wrap is lost
    next_timestamp_overflow_status = timestamp_overflow_status;
    if (wr_flag_clear)
    begin
      next_timestamp_overflow_status = 1'b0;
    end
    if (ts_overflow)
    begin
      next_timestamp_overflow_status = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      config_entered_ack <= 1'b1;
      sleep_entered_ack <= 1'b0;
      halt_entered_ack <= 1'b0;
      receive_active <= 1'b0;
      transmit_active <= 1'b0;
      timestamp_overflow_status <= 1'b0;
      pending_tx_mailbox <= `CES_SLOT_NONE;
      flag_clear_q <= 1'b0;
    end
    else
    begin
      config_entered_ack <= next_config_entered_ack;
      sleep_entered_ack <= next_sleep_entered_ack;
      halt_entered_ack <= next_halt_entered_ack;
      receive_active <= next_receive_active;
      transmit_active <= next_transmit_active;
      timestamp_overflow_status <= next_timestamp_overflow_status;
      pending_tx_mailbox <= next_pending_tx_mailbox;
      flag_clear_q <= wr_flag_clear;
    end
  end

  assign timestamp_wrap_irq_flag_clear = flag_clear_q;

  // ----------------------------------------------------------------
  // Error counters and confinement state
  // ----------------------------------------------------------------
  logic [7:0] recovery_count;
  logic [8:0] next_rx_error_count;
  logic [8:0] next_tx_error_count;
  logic [7:0] next_recovery_count;
  ces_pkg::ces_err_state_t next_err_state;
  logic [8:0] rec_sum;

  always_comb
  begin
    next_rx_error_count = rx_error_count;
    next_tx_error_count = tx_error_count;
    next_recovery_count = recovery_count;
    next_err_state = err_state;
    rec_sum = rx_error_count;
    // Receive side: stop rising past the passive limit
    if (rx_error_severe)
    begin
      rec_sum = rx_error_count + `CES_ERR_STEP_BIG;
    end
    else if (rx_error)
    begin
      rec_sum = rx_error_count + 9'd1;
    end
    if (rec_sum > `CES_PASSIVE_LIMIT)
    begin
      rec_sum = `CES_PASSIVE_LIMIT;
    end
    if (rx_success && rx_error_count == `CES_PASSIVE_LIMIT)
    begin
      next_rx_error_count = `CES_REC_RELOAD;
    end
    else if (rx_success && rx_error_count != 9'd0)
    begin
      next_rx_error_count = rx_error_count - 9'd1;
    end
    else
    begin
      next_rx_error_count = rec_sum;
    end
    // Transmit side
    if (tx_error)
    begin
      next_tx_error_count = tx_error_count + `CES_ERR_STEP_BIG;
    end
    else if (tx_success && tx_error_count != 9'd0)
    begin
      next_tx_error_count = tx_error_count - 9'd1;
    end
    unique case (err_state)
      ces_pkg::CES_BUS_OFF:
      begin
        // Counters hold no meaning here; counting ignored
        next_rx_error_count = rx_error_count;
        next_tx_error_count = tx_error_count;
        if (recessive11_seen)
        begin
          next_recovery_count = recovery_count + 8'd1;
          if (recovery_count == `CES_RECOVERY_COUNT - 8'd1)
          begin
            next_err_state = ces_pkg::CES_ERR_ACTIVE;
            next_rx_error_count = `CES_CNT_RST;
            next_tx_error_count = `CES_CNT_RST;
            next_recovery_count = 8'd0;
          end
        end
      end
      ces_pkg::CES_ERR_ACTIVE, ces_pkg::CES_ERR_PASSIVE:
      begin
        next_recovery_count = 8'd0;
        if (next_tx_error_count >= `CES_BUSOFF_LIMIT || tx_error_count >= `CES_BUSOFF_LIMIT)
        begin
          next_err_state = ces_pkg::CES_BUS_OFF;
        end
        else if (next_tx_error_count >= `CES_PASSIVE_LIMIT
          || next_rx_error_count >= `CES_PASSIVE_LIMIT)
        begin
          next_err_state = ces_pkg::CES_ERR_PASSIVE;
        end
        else
        begin
          next_err_state = ces_pkg::CES_ERR_ACTIVE;
        end
      end
      default:
        next_err_state = ces_pkg::CES_ERR_ACTIVE;
    endcase
    // Test mode load, then configuration entry clear as the last word
    if (wr_counters)
    begin
      next_rx_error_count = {1'b0, w_byte};
      next_tx_error_count = {1'b0, w_byte};
      if (err_state != ces_pkg::CES_BUS_OFF)
      begin
        next_err_state = (w_byte >= `CES_PASSIVE_LIMIT)
          ? ces_pkg::CES_ERR_PASSIVE : ces_pkg::CES_ERR_ACTIVE;
      end
    end
    if (config_entry)
    begin
      next_rx_error_count = `CES_CNT_RST;
      next_tx_error_count = `CES_CNT_RST;
      if (err_state != ces_pkg::CES_BUS_OFF)
      begin
        next_err_state = ces_pkg::CES_ERR_ACTIVE;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_error_count <= `CES_CNT_RST;
      tx_error_count <= `CES_CNT_RST;
      recovery_count <= 8'd0;
      err_state <= ces_pkg::CES_ERR_ACTIVE;
    end
    else
    begin
      rx_error_count <= next_rx_error_count;
      tx_error_count <= next_tx_error_count;
      recovery_count <= next_recovery_count;
      err_state <= next_err_state;
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  assign bus_off_status = (err_state == ces_pkg::CES_BUS_OFF);
  assign error_passive_status = (err_state == ces_pkg::CES_ERR_PASSIVE)
    || (!bus_off_status && (rx_error_count >= `CES_PASSIVE_LIMIT
    || tx_error_count >= `CES_PASSIVE_LIMIT));
  assign warning_level_status = !bus_off_status && (rx_error_count > `CES_WARN_LIMIT
    || tx_error_count > `CES_WARN_LIMIT);
  assign bus_participate_en = !bus_off_status;
  assign active_error_flag_sel = !bus_off_status && !error_passive_status;
  assign passive_error_flag_sel = !bus_off_status && error_passive_status;

  always_comb
  begin
    gsr_low = 8'h00;
    gsr_low[`CES_GLOBAL_STATE_LOW_CCE_BIT] = config_entered_ack;
    gsr_low[`CES_GLOBAL_STATE_LOW_SMA_BIT] = sleep_entered_ack;
    gsr_low[`CES_GLOBAL_STATE_LOW_HMA_BIT] = halt_entered_ack;
    gsr_low[`CES_GLOBAL_STATE_LOW_TSO_BIT] = timestamp_overflow_status;
    gsr_low[`CES_GLOBAL_STATE_LOW_BO_BIT] = bus_off_status;
    gsr_low[`CES_GLOBAL_STATE_LOW_EP_BIT] = error_passive_status;
    gsr_low[`CES_GLOBAL_STATE_LOW_EW_BIT] = warning_level_status;
    gsr_high = 8'h00;
    gsr_high[`CES_GLOBAL_STATE_HIGH_SLOT_LSB +: 4] = pending_tx_mailbox;
    gsr_high[`CES_GLOBAL_STATE_HIGH_RX_BIT] = receive_active;
    gsr_high[`CES_GLOBAL_STATE_HIGH_TX_BIT] = transmit_active;
  end

endmodule // ces_error_status

// ===== sim/ces_bus_nodes.sv
// Model of the other nodes on the shared bus, seen as event pulses
`timescale 1ns/1ps
module ces_bus_nodes
(
  input wire logic aclk,
  output logic bus_idle,
  output logic rx_error,
  output logic rx_error_severe,
  output logic tx_error,
  output logic tx_success,
  output logic rx_success,
  output logic recessive11_seen,
  output logic tx_start,
  output logic arb_lost
);
  logic [7:0] ev;
  assign {arb_lost, tx_start, recessive11_seen, rx_success} = ev[7:4];
  assign {tx_success, tx_error, rx_error_severe, rx_error} = ev[3:0];
  initial
  begin
    ev = 8'h00;
    bus_idle = 1'b1;
  end
  // One-cycle events with a quiet cycle between, so no two ever merge
  task automatic send(input int kind, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      ev <= 8'h01 << kind;
      @(posedge aclk);
      ev <= 8'h00;
    end
  endtask
  task automatic set_idle(input logic v);
    @(posedge aclk);
    bus_idle <= v;
  endtask
endmodule // ces_bus_nodes

// ===== sim/ces_error_status_monitor.sv
// Port checker for the CAN error/status block
`timescale 1ns/1ps
module ces_error_status_monitor
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic tx_error,
  input wire logic recessive11_seen,
  input wire logic bus_participate_en,
  input wire logic active_error_flag_sel,
  input wire logic passive_error_flag_sel,
  input wire logic bus_off_status,
  input wire logic error_passive_status,
  input wire logic warning_level_status,
  input wire logic timestamp_wrap_irq_flag_clear
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Runs of recessive bits seen since bus off began
  logic [7:0] rec_runs;
  logic [7:0] next_rec_runs;
  always_comb
    next_rec_runs = bus_off_status ? rec_runs + 8'(recessive11_seen) : 8'h00;
  always_ff @(posedge aclk)
    rec_runs <= aresetn ? next_rec_runs : 8'h00;
  sequence wr_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Both halves are held first, so the answer comes a cycle later than a read's
  wr_resp_a: assert property (wr_both_taken |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  rd_resp_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer missing");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  off_quiet_a: assert property (bus_off_status |-> !bus_participate_en)
    else $error("bus off node still on bus");
  act_flag_a: assert property (!error_passive_status && !bus_off_status
    |-> active_error_flag_sel && !passive_error_flag_sel) else $error("flag kind wrong");
  pas_flag_a: assert property (error_passive_status && !bus_off_status
    |-> passive_error_flag_sel && !active_error_flag_sel) else $error("flag kind wrong");
  warn_pas_a: assert property (error_passive_status |-> warning_level_status)
    else $error("passive without warning");
  off_entry_a: assert property ($rose(bus_off_status) |-> $past(tx_error))
    else $error("bus off without tx error");
  off_exit_a: assert property ($fell(bus_off_status)
    |-> rec_runs == 8'h80 && !error_passive_status) else $error("bad bus off exit");
  clr_once_a: assert property (timestamp_wrap_irq_flag_clear
    |=> !timestamp_wrap_irq_flag_clear) else $error("clear pulse too long");
endmodule // ces_error_status_monitor
bind ces_error_status ces_error_status_monitor mon (.*);

// ===== sim/test_can_error_status.sv
// Self-checking bench for the CAN error/status block
`timescale 1ns/1ps
`include "ces_defines.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module test_can_error_status;
  localparam logic [11:0] A_LOW = 12'(`CES_IDX_GSR_LOW * 4);
  localparam logic [11:0] A_HIGH = 12'(`CES_IDX_GSR_HIGH * 4);
  localparam logic [11:0] A_FLAG = 12'(`CES_IDX_GIF * 4);
  localparam logic [11:0] A_REC = 12'(`CES_IDX_REC * 4);
  localparam logic [11:0] A_TEC = 12'(`CES_IDX_TEC * 4);
  localparam int EV_RXE = 0, EV_RXS = 1, EV_TXE = 2, EV_TXOK = 3;
  localparam int EV_RXOK = 4, EV_R11 = 5, EV_TXST = 6, EV_ARB = 7;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic config_mode_in = 1'b1, sleep_mode_in = 1'b0, halt_mode_in = 1'b0;
  logic error_test_mode_bit = 1'b0, tx_slot_valid = 1'b0, ts_overflow = 1'b0;
  logic [3:0] tx_slot_mailbox = 4'h0;
  logic bus_idle, tx_start, arb_lost, rx_error, rx_error_severe, tx_error;
  logic tx_success, rx_success, recessive11_seen, bus_participate_en;
  logic active_error_flag_sel, passive_error_flag_sel, bus_off_status;
  logic error_passive_status, warning_level_status, timestamp_wrap_irq_flag_clear;
  logic [7:0] wv [4] = '{8'h60, 8'h61, 8'h7F, 8'h80};
  logic [1:0] resp;
  int err_total = 0;
  int compares = 0;
  int clr_seen = 0;
  ces_error_status dut (.*);
  ces_bus_nodes nodes (.*);
  always #20 aclk = ~aclk;
  // Flag clear pulses sent out by the block
  always @(posedge aclk)
  begin
    if (timestamp_wrap_irq_flag_clear === 1'b1)
      clr_seen <= clr_seen + 1;
  end
  // ------------------------------
  // Bus tasks
  // ------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Ready is looked at on the falling edge, where it already holds its value
  // for the next rising edge, so no race with the design's own updates
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    int n;
    n = 0;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb && n < 100)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      n++;
      @(posedge aclk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    `CHK("bvalid", 1'b1, tb)
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    `CHK("bresp", `CES_RESP_OKAY, r)
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    logic ta, tr, tv;
    logic [31:0] q;
    logic [1:0] r;
    int n;
    n = 0;
    tr = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!tr && n < 100)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tv = s_axi_rvalid;
      tr = tv && s_axi_rready;
      q = s_axi_rdata;
      r = s_axi_rresp;
      n++;
      @(posedge aclk);
      if (ta)
        s_axi_arvalid <= 1'b0;
      // Ready trails valid by a cycle, so the slave must hold its answer
      if (tv && !tr)
        s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    `CHK($sformatf("rdata %h", a), {24'h00_0000, e}, q)
    `CHK("rresp", `CES_RESP_OKAY, r)
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ------------------------------
  // Tests
  // ------------------------------
  initial
  begin
    #1_200_000;
    `CHK("watchdog", 1'b0, 1'b1)
    tally_and_finish;
  end
  initial
  begin
    tick(16);
    aresetn <= 1'b1;
    tick(1);
    rd_chk(A_LOW, 8'h80);
    rd_chk(A_HIGH, 8'hF0);
    rd_chk(A_TEC, 8'h00);
    `CHK("active sel", 1'b1, active_error_flag_sel)
    axi_wr(12'hFF0, 8'h11, resp);
    `CHK("unmapped", `CES_RESP_SLVERR, resp)
    config_mode_in <= 1'b0;
    sleep_mode_in <= 1'b1;
    tick(2);
    rd_chk(A_LOW, 8'h40);
    sleep_mode_in <= 1'b0;
    halt_mode_in <= 1'b1;
    tick(2);
    rd_chk(A_LOW, 8'h20);
    halt_mode_in <= 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      tx_slot_valid <= (i < 15);
      tx_slot_mailbox <= 4'(i);
      tick(2);
      rd_chk(A_HIGH, {4'(i), 4'h0});
    end
    $display("test modes and slot done");
    nodes.set_idle(1'b0);
    rd_chk(A_HIGH, 8'hF8);
    nodes.send(EV_TXST, 1);
    rd_chk(A_HIGH, 8'hF4);
    nodes.send(EV_ARB, 1);
    rd_chk(A_HIGH, 8'hF8);
    nodes.send(EV_TXST, 1);
    nodes.set_idle(1'b1);
    rd_chk(A_HIGH, 8'hF0);
    tick(1);
    ts_overflow <= 1'b1;
    tick(1);
    ts_overflow <= 1'b0;
    wr(A_LOW, 8'h00);
    wr(A_HIGH, 8'h00);
    wr(A_FLAG, 8'h04);
    rd_chk(A_LOW, 8'h08);
    `CHK("clear pulses", 0, clr_seen)
    rd_chk(A_HIGH, 8'hF0);
    wr(A_FLAG, 8'h08);
    rd_chk(A_LOW, 8'h00);
    `CHK("clear pulses", 1, clr_seen)
    $display("test activity and overflow done");
    wr(A_REC, 8'h55);
    rd_chk(A_REC, 8'h00);
    error_test_mode_bit <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      wr(A_TEC, wv[i]);
      rd_chk(A_REC, wv[i]);
      `CHK("warning", wv[i] > 8'h60, warning_level_status)
      `CHK("passive", wv[i] > 8'h7F, error_passive_status)
      `CHK("passive sel", wv[i] > 8'h7F, passive_error_flag_sel)
      `CHK("active sel", wv[i] < 8'h80, active_error_flag_sel)
    end
    wr(A_REC, 8'h7E);
    nodes.send(EV_RXE, 3);
    rd_chk(A_REC, 8'h80);
    `CHK("passive", 1'b1, error_passive_status)
    nodes.send(EV_TXOK, 1);
    rd_chk(A_TEC, 8'h7D);
    nodes.send(EV_RXOK, 1);
    rd_chk(A_REC, 8'h77);
    nodes.send(EV_RXS, 1);
    rd_chk(A_REC, 8'h7F);
    nodes.send(EV_TXE, 1);
    rd_chk(A_TEC, 8'h85);
    $display("test counters done");
    wr(A_TEC, 8'hF8);
    nodes.send(EV_TXE, 1);
    tick(1);
    `CHK("bus off", 1'b1, bus_off_status)
    `CHK("participate", 1'b0, bus_participate_en)
    nodes.set_idle(1'b0);
    nodes.send(EV_TXST, 1);
    rd_chk(A_HIGH, 8'hF0);
    nodes.set_idle(1'b1);
    nodes.send(EV_R11, 127);
    `CHK("bus off", 1'b1, bus_off_status)
    nodes.send(EV_R11, 1);
    tick(1);
    `CHK("bus off", 1'b0, bus_off_status)
    `CHK("participate", 1'b1, bus_participate_en)
    rd_chk(A_REC, 8'h00);
    rd_chk(A_TEC, 8'h00);
    wr(A_REC, 8'h50);
    error_test_mode_bit <= 1'b0;
    config_mode_in <= 1'b1;
    tick(2);
    rd_chk(A_TEC, 8'h00);
    rd_chk(A_LOW, 8'h80);
    $display("test bus off and config done");
    tally_and_finish;
  end
endmodule // test_can_error_status
